// >>> src/tsi_memory_access_map.sv
// Purpose: cpu access decode, page mapping and tx connection high control
// Assumes: bus strobes come from a synchronous bus front end on clk
// Notes: memories themselves live outside; this block addresses them
`timescale 1ns/10ps

module tsi_memory_access_map
    import tsi_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input wire logic clk,
    input wire logic nrst,
    // cpu port, demultiplexed address latched by the bus front end
    input wire logic [7:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    output logic [7:0] cpu_rdata,
    output logic cpu_ctl_sel,
    // mode settings from the timing-mode registers
    input wire logic [2:0] timing_mode,
    input wire logic [1:0] serial_rate,
    input wire logic [1:0] parallel_rate,
    // internal memory port
    output logic [2:0] mem_choice,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic mem_wr,
    output logic mem_rd,
    output logic block_program_req,
    input wire logic [7:0] mem_rdata,
    // rx parallel frame pulse pin
    input wire logic rx_parallel_frame_pulse,
    // per-channel transmit path
    input wire logic chan_tick,
    input wire logic [7:0] tx_conn_high_word,
    input wire logic [7:0] tx_conn_low_word,
    input wire logic [7:0] tx_data_word,
    input wire logic [7:0] rx_bypass_word,
    output logic [7:0] par_out_data,
    output logic [7:0] par_out_oe,
    output logic [3:0] external_control_lines,
    output logic [ADDR_W-1:0] source_channel_addr,
    output logic source_is_parallel
);
    // ========================================
    // elaboration checks
    if (ADDR_W != 12)
    begin : g_bad_width
        $error("tsi_memory_access_map: ADDR_W must be 12");
    end

    localparam int TSI_TICK_DIV = (TSI_CLK_MHZ * 1000) / TSI_PHASE_CLK_KHZ;
    localparam logic [4:0] TSI_TICK_LAST = 5'(TSI_TICK_DIV - 1);

    // ========================================
    // channel limit for the selected memory
    function automatic logic [11:0] chan_limit(
        input logic [2:0] choice,
        input logic [1:0] srate,
        input logic [1:0] prate
    );
        logic [11:0] lim;
        lim = TSI_CH_SER;
        case (choice)
            TSI_MEM_RX_CONN_LO, TSI_MEM_RX_CONN_HI, TSI_MEM_RX_BLOCK,
            TSI_MEM_TX_DATA:
                lim = (srate == TSI_SER_2M_BAL) ? TSI_CH_SER_BAL
                                                : TSI_CH_SER;
            default:
            begin
                case (prate)
                    TSI_PAR_HIGH: lim = TSI_CH_HIGH;
                    TSI_PAR_MID: lim = TSI_CH_MID;
                    TSI_PAR_LOW: lim = TSI_CH_LOW;
                    default: lim = TSI_CH_LOW;
                endcase
            end
        endcase
        return lim;
    endfunction

    // ========================================
    // state
    typedef struct packed {
        logic [7:0] page;
        logic [1:0] fp_sync;
        logic fp_prev;
        logic [4:0] tick_cnt;
        logic [7:0] rdata;
        logic [7:0] pdata;
        logic [7:0] poe;
        logic [3:0] ctl;
        logic [ADDR_W-1:0] src;
        logic src_par;
    } tsi_state_t;

    tsi_state_t st_ff;
    tsi_state_t nxt_st;

    logic [TSI_PHASE_W-1:0] phase_snapshot;
    logic phase_tick;
    logic frame_rise;
    logic is_mem;
    logic [ADDR_W-1:0] flat_addr;
    logic in_range;

    assign phase_tick = (st_ff.tick_cnt == TSI_TICK_LAST);
    assign frame_rise = st_ff.fp_sync[1] & ~st_ff.fp_prev;
    assign is_mem = cpu_addr[7];
    // page bits above the seven low lines; every serial and parallel
    // rate uses this one flat address, only the channel limit differs
    assign flat_addr = {st_ff.page[4:0], cpu_addr[6:0]};
    assign in_range = flat_addr < chan_limit(st_ff.page[7:5],
                                             serial_rate,
                                             parallel_rate);

    tsi_phase_snapshot u_phase
    (
        .clk(clk),
        .nrst(nrst),
        .phase_tick(phase_tick),
        .frame_pulse(frame_rise),
        .phase_snapshot(phase_snapshot)
    );

    // ========================================
    // next state
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.fp_sync = {st_ff.fp_sync[0], rx_parallel_frame_pulse};
        nxt_st.fp_prev = st_ff.fp_sync[1];
        nxt_st.tick_cnt = phase_tick ? 5'h00 : st_ff.tick_cnt + 5'h01;

        // register file; page register sits at index 0
        if (cpu_wr && !is_mem && cpu_addr[6:0] == TSI_REG_PAGE)
            nxt_st.page = cpu_wdata;
        if (cpu_rd)
        begin
            nxt_st.rdata = 8'h00;
            if (is_mem)
            begin
                if (in_range)
                    nxt_st.rdata = mem_rdata;
            end
            else
            begin
                case (cpu_addr[6:0])
                    TSI_REG_PAGE: nxt_st.rdata = st_ff.page;
                    TSI_REG_PHASE_LO: nxt_st.rdata = phase_snapshot[7:0];
                    TSI_REG_PHASE_HI:
                        nxt_st.rdata = {5'h00, phase_snapshot[10:8]};
                    default: nxt_st.rdata = 8'h00;
                endcase
            end
        end

        // per-channel transmit path, one channel per tick
        if (chan_tick)
        begin
            // message first, then bypass, then switched data
            if (tx_conn_high_word[TSI_HI_MSG])
                nxt_st.pdata = tx_conn_low_word;
            else if (tx_conn_high_word[TSI_HI_BYPASS] &&
                     (timing_mode == TSI_TM1 || timing_mode == TSI_TM2))
                nxt_st.pdata = rx_bypass_word;
            else
                nxt_st.pdata = tx_data_word;
            nxt_st.poe = {8{tx_conn_high_word[TSI_HI_OE]}};
            nxt_st.ctl[0] = tx_conn_high_word[TSI_HI_OE];
            nxt_st.ctl[1] = tx_conn_high_word[TSI_HI_CTL1];
            if (timing_mode == TSI_TM4)
            begin
                // bits 3-2 carry address there, lines held low
                nxt_st.ctl[3:2] = 2'b00;
                nxt_st.src = {tx_conn_high_word[3:0],
                              tx_conn_low_word};
                nxt_st.src_par = 1'b1;
            end
            else
            begin
                nxt_st.ctl[2] = tx_conn_high_word[TSI_HI_CTL2];
                nxt_st.ctl[3] = tx_conn_high_word[TSI_HI_CTL3];
                nxt_st.src = {3'b000, tx_conn_high_word[0],
                              tx_conn_low_word};
                nxt_st.src_par = 1'b0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            st_ff <= '0;
            st_ff.page <= TSI_PAGE_RESET;
        end
        else
            st_ff <= nxt_st;
    end

    // ========================================
    // outputs
    assign mem_choice = st_ff.page[7:TSI_CHOICE_LSB];
    assign mem_addr = flat_addr;
    assign mem_wdata = cpu_wdata;
    // out-of-range writes dropped here, reads answered with zero
    assign mem_wr = cpu_wr & is_mem & in_range;
    assign mem_rd = cpu_rd & is_mem & in_range;
    assign block_program_req = cpu_wr & is_mem &
                               (mem_choice == TSI_MEM_RX_BLOCK ||
                                mem_choice == TSI_MEM_TX_BLOCK);
    assign cpu_ctl_sel = ~is_mem;
    assign cpu_rdata = st_ff.rdata;
    assign par_out_data = st_ff.pdata;
    assign par_out_oe = st_ff.poe;
    assign external_control_lines = st_ff.ctl;
    assign source_channel_addr = st_ff.src;
    assign source_is_parallel = st_ff.src_par;
endmodule

// >>> src/tsi_pkg.sv
// Purpose: constants for the time slot interchanger cpu access block
// Assumes: 8-bit demultiplexed cpu port, 125 MHz core clock
// Notes: memory choice codes, register indices, tx high word layout
package tsi_pkg;
    // ========================================
    // register indices on the cpu port
    localparam logic [6:0] TSI_REG_PAGE = 7'h00;
    localparam logic [6:0] TSI_REG_PHASE_LO = 7'h08;
    localparam logic [6:0] TSI_REG_PHASE_HI = 7'h09;
    localparam logic [7:0] TSI_PAGE_RESET = 8'h00;
    // ========================================
    // memory choice codes (page register bits 7-5)
    localparam int TSI_CHOICE_LSB = 5;
    localparam logic [2:0] TSI_MEM_RX_CONN_LO = 3'h0;
    localparam logic [2:0] TSI_MEM_RX_CONN_HI = 3'h1;
    localparam logic [2:0] TSI_MEM_RX_DATA = 3'h2;
    localparam logic [2:0] TSI_MEM_RX_BLOCK = 3'h3;
    localparam logic [2:0] TSI_MEM_TX_CONN_LO = 3'h4;
    localparam logic [2:0] TSI_MEM_TX_CONN_HI = 3'h5;
    localparam logic [2:0] TSI_MEM_TX_DATA = 3'h6;
    localparam logic [2:0] TSI_MEM_TX_BLOCK = 3'h7;
    // ========================================
    // tx connection high word fields
    localparam int TSI_HI_OE = 7;
    localparam int TSI_HI_BYPASS = 6;
    localparam int TSI_HI_MSG = 5;
    localparam int TSI_HI_CTL1 = 4;
    localparam int TSI_HI_CTL2 = 3;
    localparam int TSI_HI_CTL3 = 2;
    // ========================================
    // serial and parallel rate codes
    localparam logic [1:0] TSI_SER_2M_BAL = 2'h0;
    localparam logic [1:0] TSI_SER_2M_ADD = 2'h1;
    localparam logic [1:0] TSI_SER_4M = 2'h2;
    localparam logic [1:0] TSI_SER_8M = 2'h3;
    localparam logic [1:0] TSI_PAR_HIGH = 2'h0;
    localparam logic [1:0] TSI_PAR_MID = 2'h1;
    localparam logic [1:0] TSI_PAR_LOW = 2'h2;
    localparam logic [11:0] TSI_CH_HIGH = 12'd2430;
    localparam logic [11:0] TSI_CH_MID = 12'd2048;
    localparam logic [11:0] TSI_CH_LOW = 12'd810;
    localparam logic [11:0] TSI_CH_SER_BAL = 12'd256;
    localparam logic [11:0] TSI_CH_SER = 12'd512;
    localparam logic [2:0] TSI_TM1 = 3'h1;
    localparam logic [2:0] TSI_TM2 = 3'h2;
    localparam logic [2:0] TSI_TM4 = 3'h4;
    // ========================================
    // phase snapshot timing
    localparam int TSI_CLK_MHZ = 125;
    localparam int TSI_PHASE_CLK_KHZ = 4096;
    localparam int TSI_PHASE_W = 11;
endpackage

// >>> src/tsi_phase_snapshot.sv
// Purpose: 11-bit serial phase snapshot against the rx parallel frame
// Assumes: phase_tick is a one-cycle pulse at 4.096 MHz rate
// Notes: frame pulse already synchronised by the caller
`timescale 1ns/10ps
module tsi_phase_snapshot
    import tsi_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic phase_tick,
    input wire logic frame_pulse,
    output logic [TSI_PHASE_W-1:0] phase_snapshot
);
    typedef struct packed {
        logic half;
        logic [8:0] cycles;
        logic odd_frame;
        logic take;
        logic [TSI_PHASE_W-1:0] snap;
    } tsi_ps_state_t;

    tsi_ps_state_t st_ff;
    tsi_ps_state_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        if (phase_tick)
        begin
            nxt_st.half = ~st_ff.half;
            if (st_ff.half)
                nxt_st.cycles = st_ff.cycles + 9'h001;
        end
        if (frame_pulse)
        begin
            // sample on every second frame, 250 us apart
            if (st_ff.take)
                nxt_st.snap = {st_ff.odd_frame, st_ff.cycles,
                               st_ff.half};
            nxt_st.take = ~st_ff.take;
            nxt_st.odd_frame = ~st_ff.odd_frame;
            nxt_st.cycles = 9'h000;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign phase_snapshot = st_ff.snap;
endmodule

// >>> testbench/tsi_map_assertions.sv
// Purpose: port checks for the cpu access map
// Assumes: one clock, synchronous active low reset
// Notes: bound to every instance of the block
`timescale 1ns/10ps
module tsi_map_chk
    import tsi_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_rdata,
    input wire logic cpu_ctl_sel,
    input wire logic [2:0] timing_mode,
    input wire logic [2:0] mem_choice,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic block_program_req,
    input wire logic [7:0] mem_rdata,
    input wire logic chan_tick,
    input wire logic [7:0] tx_conn_high_word,
    input wire logic [7:0] tx_conn_low_word,
    input wire logic [7:0] par_out_data,
    input wire logic [7:0] par_out_oe,
    input wire logic [3:0] external_control_lines
);
    // ========================================
    // cpu port
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_ctl_decode: assert property (cpu_ctl_sel == !cpu_addr[7])
        else $error("register select disagrees with address bit 7");
    a_ctl_no_mem: assert property (!cpu_addr[7] |-> !mem_rd && !mem_wr)
        else $error("memory strobe on a register access");
    a_mem_rd_gate: assert property (mem_rd |-> cpu_rd && cpu_addr[7])
        else $error("memory read without a cpu memory read");
    a_mem_wr_gate: assert property (mem_wr |-> cpu_wr && cpu_addr[7] && mem_wdata == cpu_wdata)
        else $error("memory write without matching cpu write");
    a_rd_return: assert property (mem_rd |=> cpu_rdata == $past(mem_rdata))
        else $error("read data not taken from memory");
    a_hi_zero: assert property (cpu_rd && !cpu_addr[7] && cpu_addr[6:0] == TSI_REG_PHASE_HI |=> cpu_rdata[7:3] == 5'h00)
        else $error("snapshot high byte upper bits not zero");
    a_block_req: assert property (block_program_req |-> mem_wr && mem_choice[1:0] == 2'h3)
        else $error("block program request on wrong choice");
    // ========================================
    // transmit channel path
    a_msg_first: assert property (chan_tick && tx_conn_high_word[5] |=> par_out_data == $past(tx_conn_low_word))
        else $error("message word not sent");
    a_oe_ctl: assert property (chan_tick |=> par_out_oe == {8{$past(tx_conn_high_word[7])}} && external_control_lines[0] == par_out_oe[0])
        else $error("output enable lanes or control pin 0 wrong");
    a_tm4_ctl: assert property (chan_tick && timing_mode == TSI_TM4 |=> external_control_lines[3:2] == 2'h0)
        else $error("control lines 2 and 3 driven in mode four");
    c_mem_rd: cover property (mem_rd);
    c_block: cover property (block_program_req);
    c_msg: cover property (chan_tick && tx_conn_high_word[5]);
endmodule

bind tsi_memory_access_map tsi_map_chk chk (.clk(clk), .nrst(nrst),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .cpu_ctl_sel(cpu_ctl_sel),
    .timing_mode(timing_mode), .mem_choice(mem_choice),
    .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd),
    .block_program_req(block_program_req), .mem_rdata(mem_rdata),
    .chan_tick(chan_tick), .tx_conn_high_word(tx_conn_high_word),
    .tx_conn_low_word(tx_conn_low_word), .par_out_data(par_out_data),
    .par_out_oe(par_out_oe), .external_control_lines(external_control_lines));

// >>> testbench/tsi_mem_model.sv
// Purpose: internal memory seen from the access block
// Assumes: read data must be valid in the cycle of mem_rd
// Notes: idle read bus shows inverted data so stale values never match
`timescale 1ns/10ps
module tsi_mem_model
(
    input wire logic clk,
    input wire logic [11:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_wr,
    input wire logic mem_rd,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem_ff [0:4095];
    initial
    begin
        for (int i = 0; i < 4096; i++)
            mem_ff[i] = i[7:0] ^ 8'hC3;
    end
    always @(posedge clk)
        if (mem_wr)
            mem_ff[mem_addr] <= mem_wdata;
    assign mem_rdata = mem_rd ? mem_ff[mem_addr] : ~mem_ff[mem_addr];
endmodule

// >>> testbench/tb_tsi_memory_access_map.sv
// Purpose: self-checking bench for the cpu access map
// Assumes: memory model answers in the read cycle
// Notes: frame spacing shortened, snapshot checked for shape only
`timescale 1ns/10ps
module tb_tsi_memory_access_map
    import tsi_pkg::*;
;
    logic clk = 1'b0, nrst = 1'b0, cpu_wr = 1'b0, cpu_rd = 1'b0;
    logic chan_tick = 1'b0, fp = 1'b0, cpu_ctl_sel, mem_wr, mem_rd, bp_req;
    logic src_par, wbp, wmw;
    logic [7:0] cpu_addr = 8'h00, cpu_wdata = 8'h00, hi = 8'h00, seen, p;
    logic [7:0] lo = 8'h9E, txd = 8'h3C, byp = 8'hB4;
    logic [7:0] cpu_rdata, mem_wdata, mem_rdata, pdata, poe;
    logic [2:0] tm = TSI_TM1, mem_choice;
    logic [1:0] srate = TSI_SER_2M_BAL, prate = TSI_PAR_LOW;
    logic [3:0] ctl;
    logic [11:0] mem_addr, src, wma;
    int error_cnt = 0, checks_done = 0;
    tsi_memory_access_map DUT (.clk(clk), .nrst(nrst), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
        .cpu_rdata(cpu_rdata), .cpu_ctl_sel(cpu_ctl_sel), .timing_mode(tm),
        .serial_rate(srate), .parallel_rate(prate), .mem_choice(mem_choice),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
        .mem_rd(mem_rd), .block_program_req(bp_req), .mem_rdata(mem_rdata),
        .rx_parallel_frame_pulse(fp), .chan_tick(chan_tick),
        .tx_conn_high_word(hi), .tx_conn_low_word(lo), .tx_data_word(txd),
        .rx_bypass_word(byp), .par_out_data(pdata), .par_out_oe(poe),
        .external_control_lines(ctl), .source_channel_addr(src),
        .source_is_parallel(src_par));
    tsi_mem_model m (.clk(clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));
    always #4 clk = ~clk;
    // ========================================
    // access tasks
    task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1'b1;
        // memory strobes are combinational; look once they have settled
        #2;
        wbp = bp_req;
        wmw = mem_wr;
        wma = mem_addr;
        @(negedge clk);
        cpu_wr = 1'b0;
    endtask
    // rdata holds until the next read, so a late look is safe
    task rd(input logic [7:0] a, e, mk, input string nm);
        @(negedge clk);
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(negedge clk);
        cpu_rd = 1'b0;
        @(negedge clk);
        seen = cpu_rdata;
        chk(nm, {4'h0, e}, {4'h0, seen & mk});
    endtask
    task pulse(input int gap);
        repeat (gap) @(negedge clk);
        fp = 1'b1;
        repeat (4) @(negedge clk);
        fp = 1'b0;
    endtask
    task tick(input logic [7:0] h, input logic [2:0] t, input logic [7:0] d,
        input logic [7:0] oe, input logic [3:0] c, input logic [11:0] s,
        input logic sp);
        @(negedge clk);
        hi = h;
        tm = t;
        chan_tick = 1'b1;
        @(negedge clk);
        chan_tick = 1'b0;
        chk("par_out_data", {4'h0, d}, {4'h0, pdata});
        chk("par_out_oe", {4'h0, oe}, {4'h0, poe});
        chk("control lines", {8'h0, c}, {8'h0, ctl});
        chk("source addr", s, src);
        chk("source parallel", {11'h0, sp}, {11'h0, src_par});
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ========================================
    // tests
    initial
    begin
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        rd(8'h00, TSI_PAGE_RESET, 8'hFF, "page reset");
        rd(8'h05, 8'h00, 8'hFF, "unmapped register");
        for (int c = 0; c < 8; c++)
        begin
            wr(8'h00, {c[2:0], 5'h00});
            chk("mem_choice", {9'h0, c[2:0]}, {9'h0, mem_choice});
            wr(8'h85, {c[2:0], 5'h15});
            chk("mem_addr", 12'h005, wma);
            chk("mem_wr", 12'h001, {11'h0, wmw});
            chk("block_program_req", {11'h0, c[1:0] == 2'h3},
                {11'h0, wbp});
            rd(8'h85, {c[2:0], 5'h15}, 8'hFF, "memory readback");
        end
        $display("memory choice test done");
        wr(8'h00, 8'h02);
        wr(8'h80, 8'h77);
        chk("mem_addr", 12'h100, wma);
        chk("mem_wr dropped", 12'h000, {11'h0, wmw});
        rd(8'h80, 8'h00, 8'hFF, "beyond 256");
        srate = TSI_SER_8M;
        rd(8'h80, 8'hC3, 8'hFF, "serial slot 256");
        wr(8'h00, 8'h03);
        srate = TSI_SER_2M_ADD;
        rd(8'hFF, 8'h3C, 8'hFF, "serial slot 511");
        srate = TSI_SER_4M;
        rd(8'hFF, 8'h3C, 8'hFF, "serial slot 511");
        wr(8'h00, 8'h86);
        rd(8'hAA, 8'h00, 8'hFF, "beyond 810");
        rd(8'hA9, 8'hEA, 8'hFF, "parallel 809");
        prate = TSI_PAR_MID;
        rd(8'hAA, 8'hE9, 8'hFF, "parallel 810");
        $display("range test done");
        repeat (4) pulse(1000);
        // odd flag set on every taken frame, cycle count far below 128
        rd(8'h09, 8'h04, 8'hFF, "snapshot high");
        // 1004 clocks between frames give 16 or 17 phase pairs
        rd(8'h08, 8'h20, 8'hE0, "snapshot low");
        p = seen;
        rd(8'h08, p, 8'hFF, "snapshot reread");
        pulse(777);
        repeat (40) @(negedge clk);
        rd(8'h08, p, 8'hFF, "snapshot odd frame");
        $display("snapshot test done");
        tick(8'hE1, TSI_TM1, lo, 8'hFF, 4'h1, 12'h19E, 1'b0);
        tick(8'h5C, TSI_TM1, byp, 8'h00, 4'hE, 12'h09E, 1'b0);
        tick(8'h41, TSI_TM2, byp, 8'h00, 4'h0, 12'h19E, 1'b0);
        tick(8'h60, TSI_TM2, lo, 8'h00, 4'h0, 12'h09E, 1'b0);
        tick(8'h40, 3'h3, txd, 8'h00, 4'h0, 12'h09E, 1'b0);
        tick(8'h8F, TSI_TM4, txd, 8'hFF, 4'h1, 12'hF9E, 1'b1);
        $display("transmit path test done");
        finish_test();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        finish_test();
    end
endmodule
